// [rtl/eeprom_write_path.sv]
`timescale 1ns/1ps
`default_nettype none
module eeprom_write_path #(
    parameter int unsigned PAGE_CYCLES = ee_pkg::PAGE_CYC,
    parameter logic [3:0]  DEVICE_TYPE = 4'h6 // arbitrary value
) (
    input  wire logic                      ref_clk,
    input  wire logic                      reset,
    input  wire logic                      scl_clk,
    input  wire logic                      scl_sense,
    input  wire logic                      sda_in,
    output var  logic                      sda_o,
    output var  logic                      sda_oe,
    input  wire logic [2:0]                chip_select_straps,
    input  wire logic                      vdd_low,
    output var  logic                      standby,
    output var  logic                      monitor_en,
    output var  logic                      busy,
    output var  logic                      arr_wr_en,
    output var  logic [ee_pkg::ADDR_W-1:0] arr_addr,
    output var  logic [7:0]                arr_data
);
    import ee_pkg::*;

    // link side: data bit caught on each clock rise
    logic link_bit_q = 1'b0; // data level at last rise
    logic link_tog_q = 1'b0; // flips once per rise

    // ref side synchronisers
    logic       tog_s1_q, tog_s2_q, tog_s3_q; // rise toggle
    logic       bit_s1_q, bit_s2_q;           // captured bit
    logic       scl_s1_q, scl_s2_q;           // clock level
    logic       sda_s1_q, sda_s2_q;           // data level
    logic [2:0] sel_s1_q, sel_s2_q;           // straps
    logic       vlo_s1_q, vlo_s2_q;           // low supply
    logic       bit_ev_q;                     // one bit arrived

    // filtered lines and their previous values
    logic scl_f, sda_f;
    logic scl_p_q, sda_p_q;
    logic start_ev, stop_ev, scl_fall;

    // bus engine
    bus_state_t state_q;     // current phase
    logic [3:0] cnt_q;       // bits of the byte so far
    logic [7:0] sh_q;        // shift register
    logic [7:0] sh_d;        // shift register with new bit
    logic       byte_rdy;    // eighth bit just arrived
    logic       ack_pend_q;  // ack owed at next clock fall
    logic [ADDR_W-1:0] addr_q; // start word address
    logic [5:0] ptr_q;       // cache write pointer
    logic       any_q;       // a data byte was loaded
    logic       prog_go_q;   // launch pulse to sequencer
    logic [3:0] pages_q;     // pages to program
    logic       match;       // control byte selects us

    // cache memory and valid flags
    logic [7:0]             cache_q [CACHE_BYTES];
    logic [CACHE_BYTES-1:0] valid_q;

    // sequencer wires
    logic [5:0] rd_idx;
    logic       seq_done;

    // highest loaded page plus one
    function automatic logic [3:0] page_count(
        input logic [CACHE_BYTES-1:0] v
    );
        logic [3:0] n;
        n = 4'h0;
        for (int p = 0; p < CACHE_PAGES; p++) begin
            if (|v[p*PAGE_BYTES +: PAGE_BYTES]) n = 4'(p + 1);
        end
        return n;
    endfunction

    initial begin
        if (PAGE_CYCLES < 9) $error("eeprom_write_path: PAGE_CYCLES");
    end

    // link clock domain: sample data on clock rise
    always_ff @(posedge scl_clk) begin
        link_bit_q <= sda_in;
        link_tog_q <= ~link_tog_q;
    end

    // two-stage synchronisers for every foreign level
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            bit_s1_q <= 1'b0;
            bit_s2_q <= 1'b0;
            scl_s1_q <= LINE_IDLE;
            scl_s2_q <= LINE_IDLE;
            sda_s1_q <= LINE_IDLE;
            sda_s2_q <= LINE_IDLE;
            sel_s1_q <= '0;
            sel_s2_q <= '0;
            vlo_s1_q <= 1'b0;
            vlo_s2_q <= 1'b0;
        end else begin
            tog_s1_q <= link_tog_q;
            tog_s2_q <= tog_s1_q;
            bit_s1_q <= link_bit_q;
            bit_s2_q <= bit_s1_q;
            scl_s1_q <= scl_sense;
            scl_s2_q <= scl_s1_q;
            sda_s1_q <= sda_in;
            sda_s2_q <= sda_s1_q;
            sel_s1_q <= chip_select_straps;
            sel_s2_q <= sel_s1_q;
            vlo_s1_q <= vdd_low;
            vlo_s2_q <= vlo_s1_q;
        end
    end

    // toggle edge detect, one cycle later the bit is settled
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tog_s3_q <= 1'b0;
            bit_ev_q <= 1'b0;
        end else begin
            tog_s3_q <= tog_s2_q;
            bit_ev_q <= tog_s2_q ^ tog_s3_q;
        end
    end

    // spike filters on both lines
    line_filter #(.CYCLES(FILT_CYC)) u_scl_filt (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .level_in (scl_s2_q),
        .level_q  (scl_f)
    );
    line_filter #(.CYCLES(FILT_CYC)) u_sda_filt (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .level_in (sda_s2_q),
        .level_q  (sda_f)
    );

    // previous filtered levels
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            scl_p_q <= LINE_IDLE;
            sda_p_q <= LINE_IDLE;
        end else begin
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
        end
    end

    // data edge with clock high marks START or STOP
    assign start_ev = scl_f && scl_p_q && sda_p_q && !sda_f;
    assign stop_ev  = scl_f && scl_p_q && !sda_p_q && sda_f;
    assign scl_fall = scl_p_q && !scl_f;

    // byte assembly helpers
    assign sh_d     = {sh_q[6:0], bit_s2_q};
    assign byte_rdy = bit_ev_q && cnt_q == BITS_BYTE - 4'h1;
    // device type, select bits, write direction
    assign match = sh_d[CB_TYPE_LSB +: 4] == DEVICE_TYPE
                   && sh_d[CB_SEL_LSB +: 3] == sel_s2_q
                   && sh_d[CB_RW_BIT] == RW_WRITE;

    // bit counter and shift register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cnt_q <= '0;
            sh_q  <= '0;
        end else if (start_ev) begin
            cnt_q <= '0; // fresh frame
        end else if (bit_ev_q) begin
            if (cnt_q == BITS_BYTE) begin
                cnt_q <= '0; // ack clock passed
            end else begin
                cnt_q <= cnt_q + 4'h1;
                sh_q  <= sh_d;
            end
        end
    end

    // phase machine
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q   <= ST_STANDBY;
            addr_q    <= '0;
            ptr_q     <= '0;
            any_q     <= 1'b0;
            prog_go_q <= 1'b0;
            pages_q   <= '0;
        end else begin
            prog_go_q <= 1'b0;
            case (state_q)
                ST_PROG: begin
                    // deaf to the bus until the last page ends
                    if (seq_done) state_q <= ST_STANDBY;
                end
                ST_DATA: begin
                    if (stop_ev) begin
                        if (any_q && !vlo_s2_q) begin
                            state_q   <= ST_PROG;
                            prog_go_q <= 1'b1;
                            pages_q   <= page_count(valid_q);
                        end else begin
                            state_q <= ST_STANDBY;
                        end
                    end else if (start_ev) begin
                        state_q <= ST_CTRL;
                    end else if (byte_rdy) begin
                        any_q <= 1'b1;
                        ptr_q <= ptr_q + 6'h01;
                    end
                end
                default: begin
                    if (stop_ev) begin
                        state_q <= ST_STANDBY;
                    end else if (start_ev) begin
                        state_q <= ST_CTRL;
                    end else if (byte_rdy) begin
                        case (state_q)
                            ST_CTRL: begin
                                state_q <= match ? ST_ADDR_HI
                                                 : ST_STANDBY;
                                any_q   <= 1'b0;
                            end
                            ST_ADDR_HI: begin
                                addr_q[ADDR_W-1:8] <= sh_d;
                                state_q <= ST_ADDR_LO;
                            end
                            ST_ADDR_LO: begin
                                addr_q[7:0] <= sh_d;
                                ptr_q   <= {3'h0, sh_d[2:0]};
                                state_q <= ST_DATA;
                            end
                            default: state_q <= ST_STANDBY;
                        endcase
                    end
                end
            endcase
        end
    end

    // cache writes, one byte per completed data byte
    always_ff @(posedge ref_clk) begin
        if (state_q == ST_DATA && byte_rdy && !stop_ev && !start_ev) begin
            cache_q[ptr_q] <= sh_d;
        end
    end

    // per-byte loaded flags, cleared by each new write command
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            valid_q <= '0;
        end else if (state_q == ST_CTRL && byte_rdy && match) begin
            valid_q <= '0;
        end else if (state_q == ST_DATA && byte_rdy
                     && !stop_ev && !start_ev) begin
            valid_q[ptr_q] <= 1'b1;
        end
    end

    // acknowledge: pull low from clock fall to next clock fall
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ack_pend_q <= 1'b0;
            sda_oe     <= 1'b0;
        end else begin
            if (start_ev || stop_ev) begin
                ack_pend_q <= 1'b0;
                sda_oe     <= 1'b0;
            end else if (byte_rdy) begin
                // no answer while busy or when not selected
                ack_pend_q <= (state_q == ST_CTRL) ? match
                            : (state_q == ST_ADDR_HI
                               || state_q == ST_ADDR_LO
                               || state_q == ST_DATA);
            end else if (scl_fall) begin
                if (sda_oe) begin
                    sda_oe <= 1'b0; // release after ack clock
                end else if (ack_pend_q) begin
                    sda_oe     <= 1'b1;
                    ack_pend_q <= 1'b0;
                end
            end
        end
    end

    // open drain: the driven level is always low
    always_ff @(posedge ref_clk) begin
        sda_o <= 1'b0;
    end

    // standby and supply monitor follow the phase
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            standby    <= 1'b1;
            monitor_en <= 1'b0;
        end else begin
            standby    <= state_q == ST_STANDBY;
            monitor_en <= state_q != ST_STANDBY;
        end
    end

    // page programming engine
    prog_sequencer #(.PAGE_CYCLES(PAGE_CYCLES)) u_seq (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .go        (prog_go_q),
        .pages     (pages_q),
        .base_page (addr_q[ADDR_W-1:3]),
        .inhibit   (vlo_s2_q),
        .rd_data   (cache_q[rd_idx]),
        .rd_valid  (valid_q[rd_idx]),
        .rd_idx    (rd_idx),
        .wr_en_q   (arr_wr_en),
        .wr_addr_q (arr_addr),
        .wr_data_q (arr_data),
        .busy_q    (busy),
        .done_q    (seq_done)
    );
endmodule
`default_nettype wire

// [rtl/ee_pkg.sv]
package ee_pkg;
    // clock rate and derived timing
    localparam int unsigned CLK_HZ      = 50_000_000;
    localparam int unsigned PAGE_MS     = 5;
    localparam int unsigned PAGE_CYC    = CLK_HZ / 1000 * PAGE_MS;
    localparam int unsigned FILT_NS     = 100;
    localparam int unsigned FILT_CYC    = FILT_NS * (CLK_HZ / 1_000_000)
                                          / 1000;
    // cache geometry
    localparam int unsigned CACHE_PAGES = 8;
    localparam int unsigned PAGE_BYTES  = 8;
    localparam int unsigned CACHE_BYTES = CACHE_PAGES * PAGE_BYTES;
    localparam int unsigned ADDR_W      = 16;
    // control byte fields
    localparam int unsigned CB_TYPE_LSB = 4;
    localparam int unsigned CB_SEL_LSB  = 1;
    localparam int unsigned CB_RW_BIT   = 0;
    localparam logic        RW_WRITE    = 1'b0;
    localparam logic [3:0]  BITS_BYTE   = 4'h8;
    localparam logic        LINE_IDLE   = 1'b1;
    // bus engine states
    typedef enum logic [2:0] {
        ST_STANDBY,
        ST_CTRL,
        ST_ADDR_HI,
        ST_ADDR_LO,
        ST_DATA,
        ST_PROG
    } bus_state_t;
endpackage

// [rtl/line_filter.sv]
`timescale 1ns/1ps
`default_nettype none
module line_filter #(
    parameter int unsigned CYCLES = ee_pkg::FILT_CYC
) (
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic level_in,
    output var  logic level_q
);
    import ee_pkg::*;
    localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    logic [CW-1:0] cnt_q; // cycles the input has differed

    initial begin
        if (CYCLES < 1) $error("line_filter: CYCLES must be >= 1");
    end

    // output follows only after a steady run of CYCLES samples
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            level_q <= LINE_IDLE;
            cnt_q   <= '0;
        end else if (level_in == level_q) begin
            cnt_q <= '0; // spike ended, start over
        end else if (cnt_q == CW'(CYCLES - 1)) begin
            level_q <= level_in;
            cnt_q   <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule
`default_nettype wire

// [rtl/prog_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module prog_sequencer #(
    parameter int unsigned PAGE_CYCLES = ee_pkg::PAGE_CYC
) (
    input  wire logic                      ref_clk,
    input  wire logic                      reset,
    input  wire logic                      go,
    input  wire logic [3:0]                pages,
    input  wire logic [ee_pkg::ADDR_W-4:0] base_page,
    input  wire logic                      inhibit,
    input  wire logic [7:0]                rd_data,
    input  wire logic                      rd_valid,
    output var  logic [5:0]                rd_idx,
    output var  logic                      wr_en_q,
    output var  logic [ee_pkg::ADDR_W-1:0] wr_addr_q,
    output var  logic [7:0]                wr_data_q,
    output var  logic                      busy_q,
    output var  logic                      done_q
);
    import ee_pkg::*;
    localparam int unsigned TW = $clog2(PAGE_CYCLES);
    logic [2:0]    page_q;  // cache page being programmed
    logic [2:0]    last_q;  // last cache page to program
    logic [3:0]    byte_q;  // byte slot, 8 means writes done
    logic [TW-1:0] timer_q; // cycles into the page period

    initial begin
        if (PAGE_CYCLES < 9) $error("prog_sequencer: PAGE_CYCLES < 9");
    end

    // cache slot read this cycle
    assign rd_idx = {page_q, byte_q[2:0]};

    // page walk: bytes in the first cycles of the page period, page ends when the period runs out
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
            page_q  <= '0;
            last_q  <= '0;
            byte_q  <= '0;
            timer_q <= '0;
        end else begin
            done_q <= 1'b0;
            if (go && !busy_q) begin
                busy_q  <= 1'b1;
                page_q  <= '0;
                last_q  <= 3'(pages - 4'h1);
                byte_q  <= '0;
                timer_q <= '0;
            end else if (busy_q) begin
                if (byte_q != BITS_BYTE) byte_q <= byte_q + 4'h1;
                if (timer_q == TW'(PAGE_CYCLES - 1)) begin
                    timer_q <= '0;
                    byte_q  <= '0;
                    if (page_q == last_q) begin
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                    end else begin
                        page_q <= page_q + 3'h1;
                    end
                end else begin
                    timer_q <= timer_q + 1'b1;
                end
            end
        end
    end

    // array write strobes, loaded bytes only, blocked at low supply
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wr_en_q   <= 1'b0;
            wr_addr_q <= '0;
            wr_data_q <= '0;
        end else begin
            wr_en_q   <= busy_q && byte_q != BITS_BYTE
                         && rd_valid && !inhibit;
            wr_addr_q <= {base_page + (ADDR_W-3)'(page_q),
                          byte_q[2:0]};
            wr_data_q <= rd_data;
        end
    end
endmodule
`default_nettype wire

// [bench/ee_write_path_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module ee_write_path_properties #(
    parameter int unsigned PAGE_CYCLES = ee_pkg::PAGE_CYC
) (
    input wire logic                      ref_clk,
    input wire logic                      reset,
    input wire logic                      scl_clk,
    input wire logic                      scl_sense,
    input wire logic                      sda_in,
    input wire logic                      sda_o,
    input wire logic                      sda_oe,
    input wire logic [2:0]                chip_select_straps,
    input wire logic                      vdd_low,
    input wire logic                      standby,
    input wire logic                      monitor_en,
    input wire logic                      busy,
    input wire logic                      arr_wr_en,
    input wire logic [ee_pkg::ADDR_W-1:0] arr_addr,
    input wire logic [7:0]                arr_data
);
    import ee_pkg::*;
    int unsigned run_q; // cycles the current busy span has lasted

    // busy span length, cleared whenever busy is low
    always_ff @(posedge ref_clk) begin
        if (reset || !busy) begin
            run_q <= 0;
        end else begin
            run_q <= run_q + 1;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    // acknowledge has to hold for a good part of a clock phase
    sequence ack_hold;
        sda_oe [*8];
    endsequence

    // supply low long enough to pass the synchroniser
    sequence supply_low;
        vdd_low [*4];
    endsequence

    open_drain_a: assert property (sda_oe |-> sda_o == 1'b0)
        else $error("data line driven high");
    monitor_pair_a: assert property (monitor_en == !standby)
        else $error("supply monitor enable wrong");
    busy_mute_a: assert property (busy |-> !sda_oe)
        else $error("acknowledge while programming");
    write_in_prog_a: assert property (arr_wr_en |-> busy)
        else $error("array write outside programming");
    supply_block_a: assert property (supply_low |-> !arr_wr_en)
        else $error("array write under low supply");
    ack_stands_a: assert property ($rose(sda_oe) |-> ack_hold)
        else $error("acknowledge too short");
    busy_end_a: assert property ($fell(busy) |-> ##[0:2] standby)
        else $error("no standby after programming");
    prog_time_a: assert property ($fell(busy) |->
        run_q >= PAGE_CYCLES && run_q % PAGE_CYCLES <= 1)
        else $error("programming span not whole pages");
    prog_cap_a: assert property (busy |-> run_q <= 8 * PAGE_CYCLES)
        else $error("more than eight page periods");
    standby_quiet_a: assert property (standby |-> !busy && !sda_oe)
        else $error("activity in standby");
endmodule

bind eeprom_write_path ee_write_path_properties #(
    .PAGE_CYCLES(PAGE_CYCLES)
) i_ee_write_path_properties (
    .ref_clk(ref_clk), .reset(reset), .scl_clk(scl_clk),
    .scl_sense(scl_sense), .sda_in(sda_in), .sda_o(sda_o),
    .sda_oe(sda_oe), .chip_select_straps(chip_select_straps),
    .vdd_low(vdd_low), .standby(standby), .monitor_en(monitor_en),
    .busy(busy), .arr_wr_en(arr_wr_en), .arr_addr(arr_addr),
    .arr_data(arr_data));
`default_nettype wire

// [bench/wire_master.sv]
`timescale 1ns/1ps
`default_nettype none
module wire_master #(
    parameter int unsigned HALF = 12 // link ticks per clock phase
) (
    output var  logic scl_q,
    output var  logic sda_low_q,
    input  wire logic sda_wire
);
    logic tick; // 48 ns link tick, phase free of the system clock

    // idle bus: clock and data released, clock stands still
    initial begin
        tick      = 1'b0;
        scl_q     = 1'b1;
        sda_low_q = 1'b0;
        #7;
        forever #24 tick = ~tick;
    end

    task automatic wait_t(input int n);
        repeat (n) @(posedge tick);
    endtask

    // start or repeated start: data falls while the clock is high
    task automatic put_start();
        wait_t(HALF / 2);
        sda_low_q = 1'b0;
        wait_t(HALF / 2);
        scl_q = 1'b1;
        wait_t(HALF);
        sda_low_q = 1'b1;
        wait_t(HALF);
        scl_q = 1'b0;
    endtask

    // one bit: data moves mid low phase, the wire is read at the rise
    task automatic put_bit(input logic b, output logic seen);
        wait_t(HALF / 2);
        sda_low_q = ~b;
        wait_t(HALF / 2);
        scl_q = 1'b1;
        seen  = sda_wire;
        wait_t(HALF);
        scl_q = 1'b0;
    endtask

    // eight bits, most significant first, then the acknowledge clock
    task automatic put_byte(input logic [7:0] v, output logic ack);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            put_bit(v[i], seen);
        end
        put_bit(1'b1, seen);
        ack = ~seen;
    endtask

    // stop: data rises while the clock is high, then the bus rests
    task automatic put_stop();
        wait_t(HALF / 2);
        sda_low_q = 1'b1;
        wait_t(HALF / 2);
        scl_q = 1'b1;
        wait_t(HALF);
        sda_low_q = 1'b0;
        wait_t(2 * HALF);
    endtask

    // data glitch far shorter than the input filter on an idle bus
    task automatic put_spike();
        wait_t(1);
        sda_low_q = 1'b1;
        #40;
        sda_low_q = 1'b0;
    endtask
endmodule
`default_nettype wire

// [bench/eeprom_write_path_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module eeprom_write_path_bench;
    import ee_pkg::*;
    localparam int unsigned PC  = 800;  // shortened page period
    localparam logic [3:0]  DEV = 4'h6; // arbitrary type code
    logic              ref_clk   = 1'b0;
    logic              reset     = 1'b1;
    logic              vdd_low   = 1'b0;
    logic [2:0]        straps    = 3'h5;
    wire logic         scl;
    wire logic         sda_low;
    logic              sda_o;
    logic              sda_oe;
    logic              standby;
    logic              monitor_en;
    logic              busy;
    logic              arr_wr_en;
    logic [ADDR_W-1:0] arr_addr;
    logic [7:0]        arr_data;
    wire logic         sda = ~(sda_low | (sda_oe & ~sda_o));
    logic [23:0]       got[$];        // address and data of array writes
    int                span;          // busy cycles of all programs so far
    int                err_total = 0;
    int                compares  = 0;

    always #10 ref_clk = ~ref_clk;

    // collect array writes and busy length
    always @(posedge ref_clk) begin
        if (arr_wr_en === 1'b1) got.push_back({arr_addr, arr_data});
        if (busy === 1'b1) span++;
    end

    eeprom_write_path #(.PAGE_CYCLES(PC), .DEVICE_TYPE(DEV))
    i_eeprom_write_path (
        .ref_clk(ref_clk), .reset(reset), .scl_clk(scl),
        .scl_sense(scl), .sda_in(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .chip_select_straps(straps), .vdd_low(vdd_low),
        .standby(standby), .monitor_en(monitor_en), .busy(busy),
        .arr_wr_en(arr_wr_en), .arr_addr(arr_addr), .arr_data(arr_data));

    wire_master #(.HALF(12)) i_wire_master (
        .scl_q(scl), .sda_low_q(sda_low), .sda_wire(sda));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string msg);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask

    task automatic stop_test();
        if (err_total == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // write command, optional polls around programming, array compare
    task automatic do_write(input logic [15:0] a, input int n,
                            input logic [7:0] s, input bit poll);
        logic [7:0]  cache[64];
        logic [63:0] vld;
        logic        ack;
        int          top;
        int          k;
        int          g0;
        int          s0;
        vld = '0;
        k   = 0;
        top = (a[2:0] + n - 1) / 8 + 1;
        g0  = got.size();
        i_wire_master.put_start();
        i_wire_master.put_byte({DEV, straps, RW_WRITE}, ack);
        check(ack, 1'b1, "control not acknowledged");
        i_wire_master.put_byte(a[15:8], ack);
        i_wire_master.put_byte(a[7:0], ack);
        for (int i = 0; i < n; i++) begin
            i_wire_master.put_byte(s + 8'(i), ack);
            check(ack, 1'b1, "data not acknowledged");
            cache[(a[2:0] + i) % 64] = s + 8'(i);
            vld[(a[2:0] + i) % 64]   = 1'b1;
        end
        s0 = span;
        i_wire_master.put_stop();
        if (poll) begin
            i_wire_master.put_start();
            i_wire_master.put_byte({DEV, straps, RW_WRITE}, ack);
            check(ack, 1'b0, "acknowledge while busy");
            i_wire_master.put_stop();
        end
        for (int i = 0; i < 20000 && busy !== 1'b0; i++) @(negedge ref_clk);
        check(busy, 1'b0, "programming did not end");
        if (vdd_low) vld = '0;
        if (!vdd_low)
            check((span - s0) / PC, top > 8 ? 8 : top, "pages");
        for (int p = 0; p < 8; p++) begin
            for (int b = 0; b < 8; b++) begin
                if (vld[p * 8 + b]) begin
                    check(g0 + k < got.size() ? got[g0 + k]
                          : 24'hFFFFFF,
                          {a[15:3] + 13'(p), 3'(b), cache[p * 8 + b]},
                          "array write");
                    k++;
                end
            end
        end
        check(got.size() - g0, k, "array write count");
        repeat (4) @(posedge ref_clk);
        check(standby, 1'b1, "no standby after program");
        if (poll) begin
            i_wire_master.put_start();
            i_wire_master.put_byte({DEV, straps, RW_WRITE}, ack);
            check(ack, 1'b1, "no acknowledge after program");
            i_wire_master.put_stop();
            repeat (10) @(posedge ref_clk);
            check(busy, 1'b0, "program without data");
        end
    endtask

    // control bytes with wrong type, select or direction are refused
    task automatic refuse_ctrl();
        logic [7:0] bad[3];
        logic       ack;
        bad = '{{DEV ^ 4'h1, straps, RW_WRITE},
                {DEV, straps ^ 3'h1, RW_WRITE}, {DEV, straps, ~RW_WRITE}};
        foreach (bad[j]) begin
            i_wire_master.put_start();
            i_wire_master.put_byte(bad[j], ack);
            check(ack, 1'b0, "refused control acknowledged");
            repeat (40) @(posedge ref_clk);
            check(standby, 1'b1, "no standby after refusal");
            i_wire_master.put_stop();
        end
    endtask

    // a short data glitch must not wake the device
    task automatic spike_test();
        int low;
        low = 0;
        i_wire_master.put_spike();
        repeat (30) begin
            @(negedge ref_clk);
            if (standby !== 1'b1) low++;
        end
        check(low, 0, "spike taken as bus edge");
    endtask

    // main sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        reset = 1'b0;
        repeat (2) @(posedge ref_clk);
        spike_test();
        do_write(16'h0FF8, 10, 8'h10, 1'b0);
        do_write(16'h1A1A, 66, 8'h40, 1'b1);
        refuse_ctrl();
        @(negedge ref_clk);
        straps = 3'h2;
        do_write(16'h2005, 3, 8'hA0, 1'b0);
        @(negedge ref_clk);
        vdd_low = 1'b1;
        do_write(16'h3000, 4, 8'hC0, 1'b0);
        stop_test();
    end

    // watchdog, about one and a half times the expected run
    initial begin
        #1_800_000;
        err_total++;
        stop_test();
    end
endmodule
`default_nettype wire
